/* gpib_dio_map.vh */
/*
 * constants of the i/o command and format engine.
 * assumes inclusion by bare name.
 */
`ifndef GPIB_DIO_MAP_VH
`define GPIB_DIO_MAP_VH
// format codes
`define FMT_HEX 3'h0
`define FMT_NIB 3'h1
`define FMT_BIN 3'h2
`define FMT_DEC 3'h3
`define FMT_PACK 3'h4
`define FMT_FAST 3'h5
// command and data characters
`define CH_NONE 8'h00
`define CH_X 8'h58
`define CH_D 8'h44
`define CH_Z 8'h5a
`define CH_F 8'h46
`define CH_P 8'h50
`define CH_G 8'h47
`define CH_R 8'h52
`define CH_SEMI 8'h3b
`define CH_ZERO 8'h30
`define CH_A 8'h41
`define ASCII_HI 4'h3
// argument limits
`define MAX_FMT 8'h05
`define MAX_PORT 8'h05
`define MAX_FILT 8'h02
`define MAX_RMODE 8'h01
`define MAX_OUTCNT 3'h5
// talk filter codes
`define FILT_ALL 2'h0
`define FILT_IN 2'h1
`define FILT_OUT 2'h2
// port geometry and text lengths
`define NPORT 5
`define LAST_PORT 3'h4
`define TOP_PORT 3'h5
`define PORT_BITS 7'h08
`define NIB_BITS 7'h04
`define LEN_HEX 4'h2
`define LEN_BIN 4'h9
`define LEN_DEC 4'h3
`define LEN_RAW 4'h1
`define BIN_SEP_K 4'h4
`define DEC_BASE 12'h00a
`define DEC_MAX 12'h0ff
`define DEC_100 8'h64
`define DEC_10 8'h0a
`define PACK_BYTES 3'h5
// timing
`define STROBE_TEXT_NS 50000
`define STROBE_FAST_NS 15000
`define INHIBIT_CYC 4'h2
// register word indices, reset values and status bits
`define REG_CTRL 2'h0
`define REG_TERM 2'h1
`define REG_STAT 2'h2
`define CTRL_RST 6'h00
`define TERM_RST 16'h0a0d
`define STAT_CONF 9
`define STAT_OVR 10
`endif

/* gpib_dio_pulse.v */
/*
 * retriggerable strobe pulse stretcher.
 * assumes one-cycle start requests.
 */
`timescale 1ns/1ps
`default_nettype none
module gpib_dio_pulse #(
	parameter W = 10
) (
	// clock, reset, enable
	input wire clock,
	input wire rst_n,
	input wire ce,
	// request
	input wire start,
	input wire [W-1:0] len,
	// line
	output wire pulse
);
	reg [W-1:0] cnt_r; // cycles of pulse left

	// load on start, count down otherwise
	always @(posedge clock)
	begin
		if (!rst_n)
			cnt_r <= {W{1'b0}};
		else if (ce)
		begin
			if (start)
				cnt_r <= len; // restart wins over a running pulse
			else if (cnt_r != {W{1'b0}})
				cnt_r <= cnt_r - {{(W-1){1'b0}}, 1'b1};
		end
	end

	assign pulse = cnt_r != {W{1'b0}};
endmodule // gpib_dio_pulse
`default_nettype wire

/* gpib_dio_regs.v */
/*
 * avalon-mm slave, one wait state: control, terminator, status.
 * assumes a master that holds its request.
 */
`timescale 1ns/1ps
`default_nettype none
`include "gpib_dio_map.vh"
module gpib_dio_regs (
	// clock, reset, enable
	input wire clock,
	input wire rst_n,
	input wire ce,
	// avalon-mm slave
	input wire [1:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_writedata,
	input wire [3:0] avs_byteenable,
	output reg [31:0] avs_readdata,
	output wire avs_waitrequest,
	// engine side
	input wire [11:0] stat_in,
	output reg [5:0] ctrl_r,
	output reg [15:0] term_r,
	output wire clr_conf,
	output wire clr_ovr
);
	reg ack_r; // answer cycle of the current request
	wire req = avs_read | avs_write;
	wire fire = req & ack_r & ce; // edge at which the master sees the answer
	wire stat_wr = fire & avs_write & (avs_address == `REG_STAT) & avs_byteenable[1];

	assign avs_waitrequest = req & ~ack_r;
	// write one to clear the sticky error bits
	assign clr_conf = stat_wr & avs_writedata[`STAT_CONF];
	assign clr_ovr = stat_wr & avs_writedata[`STAT_OVR];

	// first cycle latches read data, second cycle completes
	always @(posedge clock)
	begin
		if (!rst_n)
		begin
			ack_r <= 1'b0;
			avs_readdata <= 32'h0;
			ctrl_r <= `CTRL_RST;
			term_r <= `TERM_RST;
		end
		else if (ce)
		begin
			ack_r <= req & ~ack_r;
			if (req & ~ack_r)
			begin
				case (avs_address)
					`REG_CTRL: avs_readdata <= {26'h0, ctrl_r};
					`REG_TERM: avs_readdata <= {16'h0, term_r};
					`REG_STAT: avs_readdata <= {20'h0, stat_in};
					default: avs_readdata <= 32'h0; // unmapped reads zero
				endcase
			end
			if (fire & avs_write & (avs_address == `REG_CTRL) & avs_byteenable[0])
				ctrl_r <= avs_writedata[5:0];
			if (fire & avs_write & (avs_address == `REG_TERM))
			begin
				if (avs_byteenable[0])
					term_r[7:0] <= avs_writedata[7:0];
				if (avs_byteenable[1])
					term_r[15:8] <= avs_writedata[15:8];
			end
		end
	end
endmodule // gpib_dio_regs
`default_nettype wire

/* gpib_dio_command_format_engine.v */
/*
 * command buffer, interpreter and format engine of a five-port i/o unit.
 * assumes a bus front end with valid/ready byte streams, talk and clear.
 */
// What this block does
// R1 - hold commands until execute
// R2 - any execute runs the buffer
// R3 - six data encodings
// R4 - hex text is default
// R5 - nibble text: low char bits
// R6 - binary text in semicolon groups
// R7 - decimal bytes 0-255
// R8 - text data framed by D, Z
// R9 - short data fills low bits
// R10 - overflow: conflict, drop string
// R11 - text data: 50us strobe
// R12 - talk: inhibit, sample, send
// R13 - text talk keeps zeros, terminators
// R14 - one reading per addressing
// R15 - packed listen: D, five bytes
// R16 - packed talk: five bytes, eoi
// R17 - fast binary: all bytes data
// R18 - fast frames strobe 15us
// R19 - fast select sent last, bare
// R20 - fast talk resamples after eoi
// R21 - no edge latch in fast
// R22 - device clear leaves fast
// R23 - talk filter selects ports
// R24 - port selector: all or one
// R25 - edge latch, overrun error
// R26 - execute in order, then empty
`timescale 1ns/1ps
`default_nettype none
`include "gpib_dio_map.vh"
module gpib_dio_command_format_engine #(
	parameter CLK_NS = 100,
	parameter BUF_AW = 5
) (
	// clock, reset, enable
	input wire clock,
	input wire rst_n,
	input wire ce,
	// avalon-mm register slave
	input wire [1:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_writedata,
	input wire [3:0] avs_byteenable,
	output wire [31:0] avs_readdata,
	output wire avs_waitrequest,
	// listened bytes
	input wire [7:0] rx_byte,
	input wire rx_eoi,
	input wire rx_valid,
	output wire rx_ready,
	// talked bytes
	input wire talk_addressed,
	output reg [7:0] tx_byte_r,
	output reg tx_eoi_r,
	output reg tx_valid_r,
	input wire tx_ready,
	// device clear
	input wire dev_clear,
	// digital ports and handshake lines
	input wire [39:0] port_in,
	output reg [39:0] port_out_r,
	output wire [39:0] port_oe,
	input wire external_data_ready,
	output wire data_strobe,
	output reg inhibit_r
);
	localparam [31:0] STB_T = `STROBE_TEXT_NS / CLK_NS; // text strobe cycles
	localparam [31:0] STB_F = `STROBE_FAST_NS / CLK_NS; // fast strobe cycles
	localparam [1:0] E_IDLE = 2'b01, E_RUN = 2'b10;
	localparam [5:0] T_IDLE = 6'h01, T_INH = 6'h02, T_FIRST = 6'h04;
	localparam [5:0] T_LOAD = 6'h08, T_SEND = 6'h10, T_DONE = 6'h20;
	localparam [1:0] PH_DATA = 2'h0, PH_SEP = 2'h1, PH_T0 = 2'h2, PH_T1 = 2'h3;

	// hex digit value of a character
	function [3:0] hex_val;
		input [7:0] c;
		reg [7:0] t;
		begin
			t = (c >= `CH_A) ? c - `CH_A + `DEC_10 : c - `CH_ZERO;
			hex_val = t[3:0];
		end
	endfunction

	// character of a hex digit
	function [7:0] hex_chr;
		input [3:0] n;
		begin
			hex_chr = (n < 4'ha) ? `CH_ZERO + {4'h0, n} : `CH_A + {4'h0, n} - `DEC_10;
		end
	endfunction

	// characters per port in a format
	function [3:0] plen;
		input [2:0] f;
		begin
			case (f)
				`FMT_HEX, `FMT_NIB: plen = `LEN_HEX;
				`FMT_BIN: plen = `LEN_BIN;
				`FMT_DEC: plen = `LEN_DEC;
				default: plen = `LEN_RAW;
			endcase
		end
	endfunction

	// k-th character of one port byte
	function [7:0] enc;
		input [2:0] f;
		input [7:0] b;
		input [3:0] k;
		reg [3:0] nb;
		reg [3:0] bi;
		reg [7:0] dd;
		begin
			nb = (k == 4'h0) ? b[7:4] : b[3:0];
			bi = (k < `BIN_SEP_K) ? 4'h7 - k : 4'h8 - k;
			dd = (k == 4'h0) ? b / `DEC_100 : (k == 4'h1) ? (b / `DEC_10) % `DEC_10 : b % `DEC_10;
			case (f)
				`FMT_HEX: enc = hex_chr(nb); // [R4]
				`FMT_NIB: enc = {`ASCII_HI, nb}; // [R5]
				`FMT_BIN: enc = (k == `BIN_SEP_K) ? `CH_SEMI : `CH_ZERO + {7'h0, b[bi[2:0]]}; // [R6]
				`FMT_DEC: enc = `CH_ZERO + dd; // leading zeros kept [R7] [R13]
				default: enc = b;
			endcase
		end
	endfunction

	// next talked port below 'from', found bit on top
	function [3:0] next_port;
		input [2:0] from;
		input [2:0] ps;
		input [1:0] gf;
		input [2:0] oc;
		input [2:0] f;
		integer i;
		reg ok;
		begin
			next_port = 4'h0;
			for (i = 0; i < `NPORT; i = i + 1)
			begin
				if (f == `FMT_PACK || f == `FMT_FAST)
					ok = 1'b1; // binary talk always sends all five
				else if (ps != 3'h0)
					ok = (i == ps - 3'h1); // [R24]
				else
					ok = (gf == `FILT_ALL) | ((gf == `FILT_IN) & (i >= oc))
						| ((gf == `FILT_OUT) & (i < oc)); // [R23]
				if (ok && i < from)
					next_port = {1'b1, i[2:0]};
			end
		end
	endfunction

	// register file
	wire [5:0] ctrl;
	wire [15:0] term;
	wire clr_conf;
	wire clr_ovr;
	wire [2:0] ocnt = (ctrl[2:0] > `MAX_OUTCNT) ? `MAX_OUTCNT : ctrl[2:0]; // output port count
	wire eoi_dis = ctrl[3]; // no eoi after text output
	wire [1:0] term_en = ctrl[5:4]; // terminator characters enabled

	// live settings and command buffer
	reg [2:0] fmt_r, psel_r;
	reg [1:0] filt_r;
	reg edge_r; // edge latched read mode
	reg [7:0] buf_r [0:(1<<BUF_AW)-1];
	reg [BUF_AW-1:0] wr_ptr_r, rd_ptr_r;
	reg [1:0] est_r;
	reg [2:0] raw_cnt_r; // raw packed bytes left
	reg [2:0] fidx_r; // next fast byte, 0 is port five
	// working copies, committed only if the string is clean
	reg [2:0] w_fmt_r, w_psel_r;
	reg [1:0] w_filt_r;
	reg w_edge_r, w_conf_r, w_strb_r;
	reg [39:0] w_out_r;
	// parser state
	reg [7:0] pend_r; // command letter awaiting its argument
	reg [39:0] acc_r;
	reg [6:0] cnt_r; // data bits received
	reg [11:0] grp_r; // binary group or decimal number
	reg g_any_r;
	reg [2:0] pk_r;
	reg conflict_r, overrun_r;
	reg stb_go_r;
	reg [9:0] stb_len_r;

	wire fast = fmt_r == `FMT_FAST;
	wire buf_full = &wr_ptr_r;
	wire [7:0] cur = buf_r[rd_ptr_r];
	wire [7:0] dsub = cur - `CH_ZERO; // argument digit
	wire sep = (cur == `CH_SEMI) | (cur == `CH_Z);
	wire [6:0] lim = (w_psel_r != 3'h0) ? `PORT_BITS : {1'b0, ocnt, 3'h0};
	wire [5:0] pbase = {w_psel_r - 3'h1, 3'h0};
	wire [5:0] kbase = {`LAST_PORT - pk_r, 3'h0};
	wire [5:0] fbase = {`LAST_PORT - fidx_r, 3'h0};
	wire run_end = (est_r == E_RUN) & (rd_ptr_r == wr_ptr_r);
	wire conf_set = run_end & w_conf_r & ~dev_clear & ~fast;
	wire [39:0] om;
	genvar g;
	generate
		for (g = 0; g < `NPORT; g = g + 1)
		begin : gen_oe
			assign om[g*8 +: 8] = {8{g < ocnt}}; // low ports are outputs
		end
	endgenerate
	assign port_oe = om;
	assign rx_ready = fast | ((est_r == E_IDLE) & ~buf_full);

	// text data character decode
	reg [6:0] d_n;
	reg [7:0] d_val;
	reg [11:0] g_nxt;
	reg d_bad;
	reg [39:0] acc_nxt;
	always @*
	begin
		d_n = 7'h0;
		d_val = 8'h0;
		g_nxt = grp_r;
		d_bad = 1'b0;
		case (w_fmt_r)
			`FMT_HEX, `FMT_NIB:
				if (cur != `CH_Z)
				begin
					d_n = `NIB_BITS;
					d_val = {4'h0, (w_fmt_r == `FMT_HEX) ? hex_val(cur) : cur[3:0]}; // [R4] [R5]
				end
			`FMT_BIN:
				if (sep)
				begin
					g_nxt = 12'h0;
					if (g_any_r)
					begin
						d_n = `NIB_BITS; // short group keeps its omitted leading zeros [R6]
						d_val = {4'h0, grp_r[3:0]};
						d_bad = grp_r[11:4] != 8'h0;
					end
				end
				else
					g_nxt = {grp_r[10:0], cur[0]};
			`FMT_DEC:
				if (sep)
				begin
					g_nxt = 12'h0;
					if (g_any_r)
					begin
						d_n = `PORT_BITS;
						d_val = grp_r[7:0];
						d_bad = grp_r > `DEC_MAX; // [R7]
					end
				end
				else
					g_nxt = (grp_r > `DEC_MAX) ? grp_r : grp_r * `DEC_BASE + {4'h0, dsub};
			default: d_n = 7'h0;
		endcase
		acc_nxt = (d_n != 7'h0) ? (acc_r << d_n) | {32'h0, d_val} : acc_r;
	end

	// listen, buffer, execute and fast binary intake
	always @(posedge clock)
	begin
		if (!rst_n)
		begin
			fmt_r <= `FMT_HEX; // [R4]
			psel_r <= 3'h0;
			filt_r <= `FILT_ALL;
			edge_r <= 1'b0;
			port_out_r <= 40'h0;
			wr_ptr_r <= {BUF_AW{1'b0}};
			rd_ptr_r <= {BUF_AW{1'b0}};
			est_r <= E_IDLE;
			raw_cnt_r <= 3'h0;
			fidx_r <= 3'h0;
			// working copies and pending letter load on execute, parser data on its command letter, so need no reset
			conflict_r <= 1'b0;
			stb_go_r <= 1'b0;
			stb_len_r <= 10'h0;
		end
		else if (ce)
		begin
			stb_go_r <= 1'b0;
			conflict_r <= conf_set | (conflict_r & ~clr_conf); // set wins over clear [R10]
			if (dev_clear)
			begin
				// only way out of fast binary; other settings stay [R22]
				est_r <= E_IDLE;
				wr_ptr_r <= {BUF_AW{1'b0}};
				raw_cnt_r <= 3'h0;
				fidx_r <= 3'h0;
				if (fast)
					fmt_r <= `FMT_HEX;
			end
			else if (fast)
			begin
				// every byte is port data, commands included [R17] [R19]
				if (rx_valid)
				begin
					port_out_r[fbase +: 8] <= rx_byte; // [R18]
					if (fidx_r == `LAST_PORT || rx_eoi)
					begin
						fidx_r <= 3'h0;
						stb_go_r <= 1'b1; // [R18]
						stb_len_r <= STB_F[9:0];
					end
					else
						fidx_r <= fidx_r + 3'h1;
				end
			end
			else
				case (est_r)
					E_IDLE:
						if (rx_valid & ~buf_full)
						begin
							if (raw_cnt_r == 3'h0 && rx_byte == `CH_X)
							begin
								// each execute runs what is stored so far [R1] [R2]
								est_r <= E_RUN;
								rd_ptr_r <= {BUF_AW{1'b0}};
								w_fmt_r <= fmt_r;
								w_psel_r <= psel_r;
								w_filt_r <= filt_r;
								w_edge_r <= edge_r;
								w_out_r <= port_out_r;
								w_conf_r <= 1'b0;
								w_strb_r <= 1'b0;
								pend_r <= `CH_NONE;
							end
							else
							begin
								// held, no action yet; packed data may even be an execute [R1]
								buf_r[wr_ptr_r] <= rx_byte;
								wr_ptr_r <= wr_ptr_r + 1'b1;
								if (raw_cnt_r != 3'h0)
									raw_cnt_r <= raw_cnt_r - 3'h1; // [R15]
								else if (fmt_r == `FMT_PACK && rx_byte == `CH_D)
									raw_cnt_r <= `PACK_BYTES;
							end
						end
					E_RUN:
						if (run_end)
						begin
							// commit the whole string or none of it [R10] [R26]
							if (!w_conf_r)
							begin
								fmt_r <= w_fmt_r;
								psel_r <= w_psel_r;
								filt_r <= w_filt_r;
								edge_r <= w_edge_r;
								port_out_r <= w_out_r;
								fidx_r <= 3'h0;
								if (w_strb_r)
								begin
									stb_go_r <= 1'b1; // [R11]
									stb_len_r <= STB_T[9:0];
								end
							end
							wr_ptr_r <= {BUF_AW{1'b0}}; // [R26]
							est_r <= E_IDLE;
						end
						else
						begin
							rd_ptr_r <= rd_ptr_r + 1'b1; // oldest first [R26]
							if (pend_r == `CH_D && w_fmt_r == `FMT_PACK)
							begin
								// port five first, inputs dropped, unchecked [R15]
								if (om[kbase])
									w_out_r[kbase +: 8] <= cur;
								if (pk_r == `LAST_PORT)
									pend_r <= `CH_NONE;
								else
									pk_r <= pk_r + 3'h1;
							end
							else if (pend_r == `CH_D)
							begin
								// text data between D and Z [R8]
								if (d_n != 7'h0 && ({1'b0, cnt_r} + {1'b0, d_n} > {1'b0, lim} || d_bad))
									w_conf_r <= 1'b1; // [R10]
								acc_r <= acc_nxt;
								cnt_r <= cnt_r + d_n;
								grp_r <= g_nxt;
								g_any_r <= ~sep;
								if (cur == `CH_Z)
								begin
									pend_r <= `CH_NONE;
									w_strb_r <= 1'b1;
									// data in low bits, rest cleared [R9] [R24]
									if (w_psel_r != 3'h0)
										w_out_r[pbase +: 8] <= acc_nxt[7:0];
									else
										w_out_r <= acc_nxt;
								end
							end
							else if (pend_r != `CH_NONE)
							begin
								pend_r <= `CH_NONE;
								case (pend_r)
									`CH_F: if (dsub <= `MAX_FMT) w_fmt_r <= dsub[2:0]; // [R3]
									`CH_P: if (dsub <= `MAX_PORT) w_psel_r <= dsub[2:0]; // [R24]
									`CH_G: if (dsub <= `MAX_FILT) w_filt_r <= dsub[1:0]; // [R23]
									`CH_R: if (dsub <= `MAX_RMODE) w_edge_r <= dsub[0]; // [R25]
									default: pend_r <= `CH_NONE;
								endcase
							end
							else if (cur == `CH_F || cur == `CH_P || cur == `CH_G || cur == `CH_R
								|| cur == `CH_D)
							begin
								pend_r <= cur;
								acc_r <= 40'h0;
								cnt_r <= 7'h0;
								grp_r <= 12'h0;
								g_any_r <= 1'b0;
								pk_r <= 3'h0;
							end
						end
					default: est_r <= E_IDLE;
				endcase
		end
	end

	// talk side state
	reg [5:0] tst_r;
	reg [3:0] inh_cnt_r;
	reg [39:0] snap_r, latch_r;
	reg latch_v_r, edr_d_r;
	reg [2:0] tport_r;
	reg [3:0] tk_r;
	reg [1:0] ph_r;
	wire text = fmt_r < `FMT_PACK;
	wire latch_on = edge_r & ~fast; // [R21]
	wire edr_rise = external_data_ready & ~edr_d_r;
	wire consume = (tst_r == T_IDLE) & talk_addressed & latch_on & latch_v_r;
	wire [39:0] live_val = (port_out_r & om) | (port_in & ~om);
	wire [3:0] first_p = next_port(`TOP_PORT, psel_r, filt_r, ocnt, fmt_r);
	wire [3:0] np = next_port(tport_r, psel_r, filt_r, ocnt, fmt_r);
	wire [7:0] tbyte = snap_r[{tport_r, 3'h0} +: 8];
	wire eoi_ok = ~eoi_dis | ~text; // binary formats always end with eoi [R16] [R20]

	// position after the current talk character
	reg [1:0] a_ph;
	reg [2:0] a_port;
	reg [3:0] a_k;
	reg a_end;
	always @*
	begin
		a_ph = ph_r;
		a_port = tport_r;
		a_k = 4'h0;
		a_end = 1'b0;
		case (ph_r)
			PH_DATA:
				if (tk_r + 4'h1 < plen(fmt_r))
					a_k = tk_r + 4'h1;
				else if (np[3] && (fmt_r == `FMT_BIN || fmt_r == `FMT_DEC))
					a_ph = PH_SEP;
				else if (np[3])
					a_port = np[2:0];
				else if (text && term_en[0])
					a_ph = PH_T0; // [R13]
				else if (text && term_en[1])
					a_ph = PH_T1;
				else
					a_end = 1'b1; // [R16]
			PH_SEP:
			begin
				a_ph = PH_DATA;
				a_port = np[2:0];
			end
			PH_T0:
				if (term_en[1])
					a_ph = PH_T1;
				else
					a_end = 1'b1;
			default: a_end = 1'b1;
		endcase
	end

	// sample, encode and send on talk
	always @(posedge clock)
	begin
		if (!rst_n)
		begin
			tst_r <= T_IDLE;
			// sample and position registers load before use
			latch_v_r <= 1'b0;
			edr_d_r <= 1'b0;
			overrun_r <= 1'b0;
			tx_byte_r <= 8'h0;
			tx_eoi_r <= 1'b0;
			tx_valid_r <= 1'b0;
			inhibit_r <= 1'b0;
		end
		else if (ce)
		begin
			edr_d_r <= external_data_ready;
			// edge on unread data: overrun, ignored [R25]
			overrun_r <= (edr_rise & latch_on & latch_v_r & ~consume) | (overrun_r & ~clr_ovr);
			if (edr_rise & latch_on & ~latch_v_r)
			begin
				latch_r <= live_val; // [R25]
				latch_v_r <= 1'b1;
			end
			else if (consume)
				latch_v_r <= 1'b0;
			if (tst_r != T_IDLE && !talk_addressed)
			begin
				// unaddressed mid-transfer: drop the rest
				tst_r <= T_IDLE;
				tx_valid_r <= 1'b0;
				tx_eoi_r <= 1'b0;
				inhibit_r <= 1'b0;
			end
			else
				case (tst_r)
					T_IDLE:
						if (talk_addressed)
						begin
							if (latch_on)
							begin
								if (latch_v_r)
								begin
									snap_r <= latch_r; // waits for an edge before [R25]
									tst_r <= T_FIRST;
								end
							end
							else
							begin
								inhibit_r <= 1'b1; // [R12]
								inh_cnt_r <= 4'h0;
								tst_r <= T_INH;
							end
						end
					T_INH:
						if (inh_cnt_r == `INHIBIT_CYC - 4'h1)
						begin
							snap_r <= live_val; // all ports at once [R12]
							inhibit_r <= 1'b0;
							tst_r <= T_FIRST;
						end
						else
							inh_cnt_r <= inh_cnt_r + 4'h1;
					T_FIRST:
						if (first_p[3])
						begin
							tport_r <= first_p[2:0]; // [R23] [R24]
							tk_r <= 4'h0;
							ph_r <= PH_DATA;
							tst_r <= T_LOAD;
						end
						else
							tst_r <= T_DONE; // nothing selected: talker stays silent
					T_LOAD:
					begin
						case (ph_r)
							PH_DATA: tx_byte_r <= enc(fmt_r, tbyte, tk_r);
							PH_SEP: tx_byte_r <= `CH_SEMI;
							PH_T0: tx_byte_r <= term[7:0]; // [R13]
							default: tx_byte_r <= term[15:8];
						endcase
						tx_eoi_r <= a_end & eoi_ok; // [R16] [R20]
						tx_valid_r <= 1'b1;
						tst_r <= T_SEND;
					end
					T_SEND:
						if (tx_ready)
						begin
							tx_valid_r <= 1'b0;
							tx_eoi_r <= 1'b0;
							if (!a_end)
							begin
								ph_r <= a_ph;
								tport_r <= a_port;
								tk_r <= a_k;
								tst_r <= T_LOAD;
							end
							else if (fast)
							begin
								inhibit_r <= 1'b1; // resample at once [R20]
								inh_cnt_r <= 4'h0;
								tst_r <= T_INH;
							end
							else
								tst_r <= T_DONE; // [R14]
						end
					T_DONE: tst_r <= T_DONE; // left only by unaddressing [R14]
					default: tst_r <= T_IDLE;
				endcase
		end
	end

	gpib_dio_regs u_regs (
		.clock(clock),
		.rst_n(rst_n),
		.ce(ce),
		.avs_address(avs_address),
		.avs_read(avs_read),
		.avs_write(avs_write),
		.avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest),
		.stat_in({est_r == E_RUN, overrun_r, conflict_r, edge_r, filt_r, psel_r, fmt_r}),
		.ctrl_r(ctrl),
		.term_r(term),
		.clr_conf(clr_conf),
		.clr_ovr(clr_ovr)
	);

	gpib_dio_pulse #(.W(10)) u_strobe (
		.clock(clock),
		.rst_n(rst_n),
		.ce(ce),
		.start(stb_go_r),
		.len(stb_len_r),
		.pulse(data_strobe)
	);
endmodule // gpib_dio_command_format_engine
`default_nettype wire

/* gpib_dio_checker_assertions.sv */
/* checker: bus, talk and strobe timing.
   bound to the engine top, one clock. */
`timescale 1ns/1ps
`default_nettype none
module gpib_dio_checker (
	// clock, reset, bus
	input wire clock,
	input wire rst_n,
	input wire avs_read,
	input wire avs_write,
	input wire avs_waitrequest,
	// talk side and lines
	input wire [7:0] tx_byte_r,
	input wire tx_valid_r,
	input wire tx_ready,
	input wire talk_addressed,
	input wire data_strobe,
	input wire inhibit_r
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	reg [15:0] hi_cnt_r; // strobe high cycles so far
	// width of the running strobe pulse
	always @(posedge clock)
	begin
		if (!rst_n || !data_strobe)
			hi_cnt_r <= 16'h0000;
		else
			hi_cnt_r <= hi_cnt_r + 16'h0001;
	end
	a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("wait state too long");
	a_wait_idle: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
		else $error("wait without request");
	a_tx_hold: assert property (tx_valid_r && !tx_ready && talk_addressed |=> tx_valid_r && $stable(tx_byte_r))
		else $error("talk byte changed before taken");
	a_inhib_len: assert property ($rose(inhibit_r) |-> inhibit_r ##1 inhibit_r ##1 !inhibit_r)
		else $error("inhibit width wrong");
	a_inhib_cause: assert property ($rose(inhibit_r) |-> $past(talk_addressed))
		else $error("inhibit without talk");
	a_inhib_quiet: assert property (inhibit_r |-> !tx_valid_r)
		else $error("byte sent during inhibit");
	a_talk_idle: assert property (!talk_addressed ##1 !talk_addressed |-> !tx_valid_r)
		else $error("talk while not addressed");
	a_strobe_len: assert property ($fell(data_strobe) |-> hi_cnt_r == 16'h01f4 || hi_cnt_r == 16'h0096)
		else $error("strobe width wrong");
endmodule // gpib_dio_checker
bind gpib_dio_command_format_engine gpib_dio_checker u_gpib_dio_checker (.clock, .rst_n,
	.avs_read, .avs_write, .avs_waitrequest, .tx_byte_r, .tx_valid_r, .tx_ready,
	.talk_addressed, .data_strobe, .inhibit_r);
`default_nettype wire

/* gpib_ctrl_model.sv */
/* bus controller model: listen strings, talk bytes.
   assumes valid/ready handshakes. */
`timescale 1ns/1ps
`default_nettype none
module gpib_ctrl_model (
	// clock
	input wire logic clock,
	// listen stream
	output logic [7:0] rx_byte,
	output logic rx_eoi,
	output logic rx_valid,
	input wire logic rx_ready,
	// talk stream
	output logic talk_addressed,
	input wire logic [7:0] tx_byte_r,
	input wire logic tx_eoi_r,
	input wire logic tx_valid_r,
	output logic tx_ready
);
	logic [8:0] got[$]; // eoi flag and byte of each talked unit
	initial
		{rx_byte, rx_eoi, rx_valid, talk_addressed, tx_ready} = '0;
	// strings as given by the
	task automatic send(input string s, input logic eoi_last);
		for (int i = 0; i < s.len(); i++)
		begin
			rx_byte <= s[i];
			rx_eoi <= eoi_last && (i == s.len() - 1);
			rx_valid <= 1'b1;
			do @(posedge clock); while (rx_ready !== 1'b1);
		end
		// released line shows the inverse
		rx_byte <= ~rx_byte;
		rx_eoi <= 1'b0;
		rx_valid <= 1'b0;
		@(posedge clock);
	endtask
	// one addressing per reading, ready toggling
	task automatic talk(input int n);
		got.delete();
		talk_addressed <= 1'b1;
		while (got.size() < n)
		begin
			@(posedge clock);
			if (tx_valid_r === 1'b1 && tx_ready === 1'b1)
				got.push_back({tx_eoi_r, tx_byte_r});
			tx_ready <= ~tx_ready;
		end
		talk_addressed <= 1'b0;
		tx_ready <= 1'b0;
		@(posedge clock);
	endtask
endmodule // gpib_ctrl_model
`default_nettype wire

/* gpib_dio_command_format_engine_bench.sv */
/* bench: registers, listen, talk, fast binary.
   assumes the model and bound checker. */
`timescale 1ns/1ps
`default_nettype none
`include "gpib_dio_map.vh"
module gpib_dio_command_format_engine_bench;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic avs_read = 1'b0, avs_write = 1'b0, dev_clear = 1'b0;
	logic [1:0] avs_address = 2'h0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata, v;
	logic [7:0] rx_byte, tx_byte_r;
	logic avs_waitrequest, rx_eoi, rx_valid, rx_ready, talk_addressed, tx_ready;
	logic tx_eoi_r, tx_valid_r, data_strobe, inhibit_r;
	logic [39:0] port_out_r, port_oe;
	int n_fail = 0, compares = 0, width = 0, cur = 0, n_inh = 0;
	always #50 clock = ~clock;
	gpib_dio_command_format_engine u_gpib_dio_command_format_engine (.clock, .rst_n, .ce(1'b1),
		.avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable(4'hf), .avs_readdata,
		.avs_waitrequest, .rx_byte, .rx_eoi, .rx_valid, .rx_ready, .talk_addressed, .tx_byte_r,
		.tx_eoi_r, .tx_valid_r, .tx_ready, .dev_clear, .port_in(40'h5a5a5a5a5a), .port_out_r,
		.port_oe, .external_data_ready(1'b0), .data_strobe, .inhibit_r);
	gpib_ctrl_model u_gpib_ctrl_model (.clock, .rx_byte, .rx_eoi, .rx_valid, .rx_ready,
		.talk_addressed, .tx_byte_r, .tx_eoi_r, .tx_valid_r, .tx_ready);
	// strobe width and inhibit cycles at the pins
	always @(posedge clock)
	begin
		if (inhibit_r === 1'b1)
			n_inh++;
		if (data_strobe === 1'b1)
			cur++;
		else if (cur != 0)
		begin
			width = cur;
			cur = 0;
		end
	end
	task automatic chk(input string nm, input logic [39:0] e, input logic [39:0] g);
		compares++;
		if (g !== e)
		begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	// one access, held until waitrequest low
	task automatic acc(input logic wr, input logic [1:0] a, input logic [31:0] d);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		do @(posedge clock); while (avs_waitrequest !== 1'b0);
		v = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge clock);
	endtask
	// send, then poll until idle
	task automatic cmd(input string s);
		u_gpib_ctrl_model.send(s, 1'b0);
		do acc(1'b0, 2'h2, 32'h0); while (v[11] !== 1'b0);
		repeat (2) @(posedge clock);
	endtask
	// the extra edge lets the width monitor land first
	task automatic pulse();
		while (data_strobe !== 1'b1) @(posedge clock);
		while (data_strobe !== 1'b0) @(posedge clock);
		@(posedge clock);
	endtask
	task automatic results();
		$display("compares %0d mismatches %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// watchdog, far beyond the run
	initial
	begin
		repeat (20000) @(posedge clock);
		n_fail++;
		results();
	end
	initial
	begin
		repeat (12) @(posedge clock);
		rst_n <= 1'b1;
		@(posedge clock);
		acc(1'b0, 2'h3, 32'h0);
		chk("unmapped", 40'h0, {8'h00, v});
		acc(1'b0, 2'h2, 32'h0);
		chk("format", {37'h0, `FMT_HEX}, {37'h0, v[2:0]});
		acc(1'b1, 2'h0, 32'h2);
		acc(1'b0, 2'h0, 32'h0);
		chk("outcnt", 40'h2, {8'h00, v});
		chk("oe", 40'hffff, port_oe);
		$display("registers done");
		u_gpib_ctrl_model.send("D1234Z", 1'b0);
		chk("held", 40'h0, port_out_r);
		cmd("X");
		pulse();
		chk("hex", 40'h1234, port_out_r);
		chk("strobe", `STROBE_TEXT_NS / 100, width);
		cmd("D5ZX");
		pulse();
		chk("short", 40'h5, port_out_r);
		cmd("D12345ZX");
		chk("kept", 40'h5, port_out_r);
		chk("conflict", 40'h1, {39'h0, v[`STAT_CONF]});
		cmd("F1XD:?ZX");
		pulse();
		chk("nibble", 40'haf, port_out_r);
		cmd("F3XD200ZX");
		pulse();
		chk("decimal", 40'hc8, port_out_r);
		cmd("F2XD1;101ZX");
		pulse();
		chk("binary", 40'h15, port_out_r);
		$display("listen done");
		cmd("F0P1X");
		n_inh = 0;
		u_gpib_ctrl_model.talk(2);
		chk("talk0", 40'h031, {31'h0, u_gpib_ctrl_model.got[0]});
		chk("talk1", 40'h135, {31'h0, u_gpib_ctrl_model.got[1]});
		chk("inhibit", `INHIBIT_CYC, n_inh);
		$display("talk done");
		cmd("F5X");
		u_gpib_ctrl_model.send("ab", 1'b1);
		pulse();
		chk("fast", 40'h6162000015, port_out_r);
		chk("fstrobe", `STROBE_FAST_NS / 100, width);
		dev_clear <= 1'b1;
		@(posedge clock);
		dev_clear <= 1'b0;
		acc(1'b0, 2'h2, 32'h0);
		chk("clear", {37'h0, `FMT_HEX}, {37'h0, v[2:0]});
		$display("fast done");
		results();
	end
endmodule // gpib_dio_command_format_engine_bench
`default_nettype wire
